//--- hw/pmi_pkg.sv
// constants, carriers and states shared by the command interpreter files
package pmi_pkg;
	localparam logic [3:0]  DEV_ADDR_HI          = 4'h8;
	localparam logic [7:0]  GEN_CALL_ADDR        = 8'h00;
	localparam logic [7:0]  OPERATION_CMD        = 8'h01;
	localparam logic [7:0]  CLEAR_FAULTS_CMD     = 8'h03;
	localparam logic [7:0]  VOUT_SET_CMD         = 8'h21;
	localparam logic [7:0]  OVERVOLTAGE_TRIP_CMD = 8'h40;
	localparam logic [7:0]  READ_STATUS_CMD      = 8'hd0;
	localparam int          AUX_CMD_N            = 14;
	localparam logic [7:0]  AUX_CMDS [AUX_CMD_N] = '{8'hd2, 8'hd3, 8'hd6, 8'hd7, 8'hd8, 8'hd9,
		8'hda, 8'hdc, 8'hdd, 8'hde, 8'hdf, 8'he0, 8'he1, 8'he2};
	localparam logic [7:0]  OP_ON_BYTE           = 8'h80;
	localparam logic [7:0]  OP_OFF_BYTE          = 8'h00;
	localparam int          VOUT_SCALE           = 400;
	localparam int          VOUT_MIN_V           = 42;
	localparam int          VOUT_MAX_V           = 58;
	localparam logic [15:0] VOUT_MIN_CODE        = 16'(VOUT_MIN_V * VOUT_SCALE);
	localparam logic [15:0] VOUT_MAX_CODE        = 16'(VOUT_MAX_V * VOUT_SCALE);
	localparam logic [15:0] VOUT_RST_CODE        = VOUT_MIN_CODE;
	localparam logic [15:0] OVLIM_RST_CODE       = 16'hffff;
	localparam logic [7:0]  BLK_COUNT            = 8'h09;
	localparam logic [3:0]  BLK_PEC_IDX          = 4'h9;
	localparam logic [7:0]  CRC_POLY             = 8'h07;
	localparam logic [7:0]  IDLE_BYTE            = 8'hff;
	localparam int          ST1_ISO_OK_BIT       = 6;

	// restart_and_command_flags, msb first
	typedef struct packed {
		logic checksum_mismatch_flag;
		logic will_restart;
		logic bad_cmd;
		logic high_line;
		logic iso_fail;
		logic restarted;
		logic value_range_flag;
		logic remote_enable_level_flag;
	} pmi_st2_t;

	typedef struct packed {
		logic       start;
		logic       stop;
		logic       addr;
		logic       rd;
		logic       rx;
		logic       tx;
		logic [7:0] data;
	} pmi_evt_t;

	typedef enum logic [6:0] {
		ST_IDLE = 7'b0000001,
		ST_ADDR = 7'b0000010,
		ST_RX   = 7'b0000100,
		ST_ACK  = 7'b0001000,
		ST_TX   = 7'b0010000,
		ST_MACK = 7'b0100000,
		ST_TXW  = 7'b1000000
	} pmi_bst_t;
endpackage

//--- hw/pmi_pec.sv
// crc-8 packet error code accumulator, one byte per strobe
`timescale 1ns/1ps
module pmi_pec
	import pmi_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic       clr,
	input  wire logic       en,
	input  wire logic [7:0] din,
	output logic      [7:0] crc
);
	logic [7:0] crc_q;
	logic [7:0] crc_d;
	logic [7:0] c;

	always_comb begin
		c = crc_q ^ din;
		for (int i = 0; i < 8; i++) begin
			c = c[7] ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
		end
		crc_d = clr ? 8'h00 : (en ? c : crc_q);
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			crc_q <= 8'h00;
		end else begin
			crc_q <= crc_d;
		end
	end

	assign crc = crc_q;
endmodule

//--- hw/pmi_bit_engine.sv
// two-wire slave bit engine: pin sampling, start/stop, byte shift, acknowledge
`timescale 1ns/1ps
module pmi_bit_engine
	import pmi_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	input  wire logic [2:0] addr_sel,
	input  wire logic [7:0] tx_byte,
	output pmi_evt_t        ev
);
	logic [1:0] r1_q, r2_q, r3_q, f_q, f_d;
	pmi_bst_t   st_q, st_d;
	logic [2:0] bit_q, bit_d;
	logic [7:0] sh_q, sh_d, rxb;
	logic       oe_q, oe_d, ackon_q, ackon_d, rd_q, rd_d;
	logic       rise, fall, start, stop, hit;
	pmi_evt_t   ev_q, ev_d;

	// bit 1 is the clock line, bit 0 the data line
	always_comb begin
		f_d   = ((r2_q ~^ r3_q) & r3_q) | (~(r2_q ~^ r3_q) & f_q);
		rise  = f_d[1] & ~f_q[1];
		fall  = ~f_d[1] & f_q[1];
		start = f_q[1] & f_d[1] & f_q[0] & ~f_d[0];
		stop  = f_q[1] & f_d[1] & ~f_q[0] & f_d[0];
		rxb   = {sh_q[6:0], f_d[0]};
		hit   = (rxb[7:1] == {DEV_ADDR_HI, addr_sel}) | (rxb == GEN_CALL_ADDR);
	end

	always_comb begin
		st_d    = st_q;
		bit_d   = bit_q;
		sh_d    = sh_q;
		oe_d    = oe_q;
		ackon_d = ackon_q;
		rd_d    = rd_q;
		ev_d    = '0;
		ev_d.data = ev_q.data;
		if (stop) begin
			st_d = ST_IDLE;
			oe_d = 1'b0;
			ev_d.stop = 1'b1;
		end else if (start) begin
			st_d    = ST_ADDR;
			bit_d   = 3'd0;
			oe_d    = 1'b0;
			ackon_d = 1'b0;
			ev_d.start = 1'b1;
		end else begin
			unique case (st_q)
				ST_IDLE: ;
				ST_ADDR, ST_RX: if (rise) begin
					sh_d  = rxb;
					bit_d = bit_q + 3'd1;
					if (bit_q == 3'd7) begin
						ev_d.data = rxb;
						st_d = ST_ACK;
						if (st_q == ST_RX) begin
							ev_d.rx = 1'b1;
						end else if (hit && !(rxb == 8'h01)) begin
							rd_d = rxb[0];
							ev_d.addr = 1'b1;
							ev_d.rd = rxb[0];
						end else begin
							st_d = ST_IDLE;
						end
					end
				end
				ST_ACK: if (fall) begin
					if (!ackon_q) begin
						oe_d    = 1'b1;
						ackon_d = 1'b1;
					end else begin
						ackon_d = 1'b0;
						oe_d    = 1'b0;
						bit_d   = 3'd0;
						st_d    = ST_RX;
						if (rd_q) begin
							st_d = ST_TX;
							sh_d = tx_byte;
							oe_d = ~tx_byte[7];
							ev_d.tx = 1'b1;
							ev_d.data = tx_byte;
						end
					end
				end
				ST_TX: begin
					if (rise) begin
						bit_d = bit_q + 3'd1;
						if (bit_q == 3'd7) begin
							st_d = ST_MACK;
						end
					end else if (fall) begin
						sh_d = {sh_q[6:0], 1'b0};
						oe_d = ~sh_q[6];
					end
				end
				// a not-acknowledge ends the read; the stop follows
				ST_MACK: begin
					if (fall) begin
						oe_d = 1'b0;
					end else if (rise) begin
						st_d = f_d[0] ? ST_IDLE : ST_TXW;
					end
				end
				ST_TXW: if (fall) begin
					st_d  = ST_TX;
					bit_d = 3'd0;
					sh_d  = tx_byte;
					oe_d  = ~tx_byte[7];
					ev_d.tx = 1'b1;
					ev_d.data = tx_byte;
				end
				default: st_d = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			r1_q    <= 2'h3;
			r2_q    <= 2'h3;
			r3_q    <= 2'h3;
			f_q     <= 2'h3;
			st_q    <= ST_IDLE;
			bit_q   <= 3'd0;
			sh_q    <= 8'h00;
			oe_q    <= 1'b0;
			ackon_q <= 1'b0;
			rd_q    <= 1'b0;
			ev_q    <= '0;
		end else begin
			r1_q    <= {scl_in, sda_in};
			r2_q    <= r1_q;
			r3_q    <= r2_q;
			f_q     <= f_d;
			st_q    <= st_d;
			bit_q   <= bit_d;
			sh_q    <= sh_d;
			oe_q    <= oe_d;
			ackon_q <= ackon_d;
			rd_q    <= rd_d;
			ev_q    <= ev_d;
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe  = oe_q;
	assign ev      = ev_q;
endmodule

//--- hw/pmi_cmd_interp.sv
// command decoder and status reporting for the rectifier management slave
// What this block does
// - command 01 with byte 80 turns output on, byte 00 turns it off.
// - after reset the output is on while remote enable is held low.
// - a restart from off clears alarms and latched shutdowns.
// - command 03 clears isolation, restart, command and checksum flags, but not the data flag.
// - command 21 carries a setpoint, low byte first, 400 counts per volt.
// - accepted setpoints lie between 42 and 58 volts.
// - a bus setpoint overrides margin input and default until power loss.
// - command 40 with two bytes loads the overvoltage shutdown threshold.
// - block read answers with a byte count that includes the checksum.
// - multi-byte values go out low byte first, then high byte.
// - code D0 returns count 9, status, alarms, volts, amps, temperature, checksum.
// - every error bit reads 1 for alarm and 0 for normal.
// - checksum mismatch sets status bit 7 and the command is dropped.
// - status bit 6 shows the unit restarts automatically after shutdown.
// - unsupported code sets status bit 5 and asserts the alert output.
// - status bit 4 shows high-line power capacity.
// - status bit 3 reports failed isolation test, with no fault reaction.
// - status bit 2 is set after a successful restart.
// - status bit 1 flags bad data and holds until valid data arrives.
// - status bit 0 mirrors the remote enable pin, 1 meaning off.
`timescale 1ns/1ps
module pmi_cmd_interp
	import pmi_pkg::*;
#(
	parameter logic [15:0] VOUT_DEF  = VOUT_RST_CODE,
	parameter logic [15:0] OVLIM_DEF = OVLIM_RST_CODE
) (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	input  wire logic [2:0]  addr_sel,
	input  wire logic        remote_en_n,
	input  wire logic        margin_sel,
	input  wire logic [15:0] margin_code,
	input  wire logic        auto_restart_cfg,
	input  wire logic        high_line,
	input  wire logic        iso_pass,
	input  wire logic        iso_fail,
	input  wire logic [7:0]  status1_in,
	input  wire logic [7:0]  alarm2_in,
	input  wire logic [7:0]  alarm1_in,
	input  wire logic [15:0] vout_meas,
	input  wire logic [7:0]  iout_meas,
	input  wire logic [7:0]  temp_meas,
	output logic             out_enable,
	output logic [15:0]      vout_target,
	output logic [15:0]      ov_trip_level,
	output logic             restart_clear,
	output logic             alert_n
);
	// pin order: margin select, remote enable, address straps
	logic [4:0]  p1_q, p2_q, p3_q, pf_q, pf_d;
	logic        remote_lvl;
	pmi_evt_t    ev;
	logic [7:0]  tx_byte;
	logic [7:0]  crc;
	logic        crc_clr;
	logic        crc_en;

	logic        inframe_q, inframe_d;
	logic        cmdv_q, cmdv_d;
	logic [7:0]  cmd_q, cmd_d;
	logic [2:0]  nb_q, nb_d;
	logic [7:0]  b0_q, b0_d;
	logic [7:0]  b1_q, b1_d;
	logic        rdph_q, rdph_d;
	logic [3:0]  idx_q, idx_d;
	logic        bad_set;
	logic        wr_end;
	logic        wr_ok;
	logic        pec_bad;
	logic [15:0] word;

	logic        on_q, on_d;
	logic        eff_q, eff_d;
	logic        rsc_q, rsc_d;
	logic        sw_q, sw_d;
	logic [15:0] sp_q, sp_d;
	logic [15:0] ov_q, ov_d;
	logic [15:0] vt_q, vt_d;
	logic        restart;
	logic        clr;
	logic        clr_any;
	logic        rng_set;
	logic        rng_clr;

	logic        pec_q, pec_d;
	logic        bad_q, bad_d;
	logic        isof_q, isof_d;
	logic        isok_q, isok_d;
	logic        rok_q, rok_d;
	logic        rng_q, rng_d;
	pmi_st2_t    st2;
	logic [7:0]  st1;

	function automatic logic known_cmd(input logic [7:0] c);
		logic k;
		k = (c == OPERATION_CMD) || (c == CLEAR_FAULTS_CMD) || (c == VOUT_SET_CMD) ||
			(c == OVERVOLTAGE_TRIP_CMD) || (c == READ_STATUS_CMD);
		for (int i = 0; i < AUX_CMD_N; i++) begin
			k = k | (c == AUX_CMDS[i]);
		end
		return k;
	endfunction

	function automatic logic [2:0] need_bytes(input logic [7:0] c);
		logic [2:0] n;
		n = 3'd0;
		if (c == OPERATION_CMD) begin
			n = 3'd1;
		end else if (c == VOUT_SET_CMD || c == OVERVOLTAGE_TRIP_CMD) begin
			n = 3'd2;
		end
		return n;
	endfunction

	pmi_bit_engine u_bits (
		.clk_sys  (clk_sys),
		.rst      (rst),
		.scl_in   (scl_in),
		.sda_in   (sda_in),
		.sda_out  (sda_out),
		.sda_oe   (sda_oe),
		.addr_sel (pf_q[2:0]),
		.tx_byte  (tx_byte),
		.ev       (ev)
	);

	// the checksum spans both halves of a read, so only a fresh start clears it
	assign crc_clr = ev.start & ~inframe_q;
	assign crc_en  = ev.addr | ev.rx | ev.tx;

	pmi_pec u_pec (
		.clk_sys (clk_sys),
		.rst     (rst),
		.clr     (crc_clr),
		.en      (crc_en),
		.din     (ev.data),
		.crc     (crc)
	);

	always_comb begin
		pf_d       = ((p2_q ~^ p3_q) & p3_q) | (~(p2_q ~^ p3_q) & pf_q);
		remote_lvl = pf_q[3];
	end

	always_comb begin
		inframe_d = inframe_q;
		cmdv_d    = cmdv_q;
		cmd_d     = cmd_q;
		nb_d      = nb_q;
		b0_d      = b0_q;
		b1_d      = b1_q;
		rdph_d    = rdph_q;
		idx_d     = idx_q;
		bad_set   = 1'b0;
		if (ev.start) begin
			if (!inframe_q) begin
				cmdv_d = 1'b0;
				rdph_d = 1'b0;
			end
			inframe_d = 1'b1;
		end
		if (ev.stop) begin
			inframe_d = 1'b0;
		end
		if (ev.addr && ev.rd) begin
			rdph_d = 1'b1;
			idx_d  = 4'h0;
		end
		if (ev.rx) begin
			if (!cmdv_q) begin
				cmd_d   = ev.data;
				cmdv_d  = 1'b1;
				nb_d    = 3'd0;
				bad_set = !known_cmd(ev.data);
			end else begin
				if (nb_q == 3'd0) begin
					b0_d = ev.data;
				end
				if (nb_q == 3'd1) begin
					b1_d = ev.data;
				end
				if (nb_q != 3'd7) begin
					nb_d = nb_q + 3'd1;
				end
			end
		end
		if (ev.tx && idx_q != 4'hf) begin
			idx_d = idx_q + 4'h1;
		end
	end

	// a write ends at stop with exactly its data bytes plus the checksum
	always_comb begin
		wr_end  = ev.stop & cmdv_q & ~rdph_q & (nb_q == need_bytes(cmd_q) + 3'd1);
		wr_ok   = wr_end & (crc == 8'h00);
		pec_bad = wr_end & (crc != 8'h00);
		word    = {b1_q, b0_q};
	end

	always_comb begin
		on_d    = on_q;
		sp_d    = sp_q;
		sw_d    = sw_q;
		ov_d    = ov_q;
		clr     = 1'b0;
		rng_set = 1'b0;
		rng_clr = 1'b0;
		if (wr_ok) begin
			case (cmd_q)
				OPERATION_CMD: begin
					if (b0_q == OP_ON_BYTE) begin
						on_d    = 1'b1;
						rng_clr = 1'b1;
					end else if (b0_q == OP_OFF_BYTE) begin
						on_d    = 1'b0;
						rng_clr = 1'b1;
					end else begin
						rng_set = 1'b1;
					end
				end
				VOUT_SET_CMD: begin
					if (word >= VOUT_MIN_CODE && word <= VOUT_MAX_CODE) begin
						sp_d    = word;
						sw_d    = 1'b1;
						rng_clr = 1'b1;
					end else begin
						rng_set = 1'b1;
					end
				end
				OVERVOLTAGE_TRIP_CMD: ov_d = word;
				CLEAR_FAULTS_CMD: clr = 1'b1;
				default: ;
			endcase
		end
		// only the remote pin or the operation byte can turn the output off
		eff_d   = on_q & ~remote_lvl;
		restart = eff_d & ~eff_q;
		rsc_d   = restart;
		clr_any = clr | restart;
		// a bus setpoint wins until reset; margin pin then has no effect
		vt_d = sw_q ? sp_q : (pf_q[4] ? margin_code : VOUT_DEF);
	end

	// every sticky flag: a set in the same cycle as a clear wins
	always_comb begin
		pec_d  = pec_bad | (pec_q & ~clr_any);
		bad_d  = bad_set | (bad_q & ~clr_any);
		isof_d = iso_fail | (isof_q & ~clr_any);
		isok_d = iso_pass | (isok_q & ~clr_any);
		rok_d  = restart | (rok_q & ~clr);
		rng_d  = rng_set | (rng_q & ~rng_clr);
	end

	always_comb begin
		st2.checksum_mismatch_flag   = pec_q;
		st2.will_restart             = auto_restart_cfg;
		st2.bad_cmd                  = bad_q;
		st2.high_line                = high_line;
		st2.iso_fail                 = isof_q;
		st2.restarted                = rok_q;
		st2.value_range_flag         = rng_q;
		st2.remote_enable_level_flag = remote_lvl;
		st1                 = status1_in;
		st1[ST1_ISO_OK_BIT] = isok_q;
	end

	always_comb begin
		tx_byte = IDLE_BYTE;
		if (cmdv_q && cmd_q == READ_STATUS_CMD) begin
			case (idx_q)
				4'h0: tx_byte = BLK_COUNT;
				4'h1: tx_byte = st2;
				4'h2: tx_byte = st1;
				4'h3: tx_byte = alarm2_in;
				4'h4: tx_byte = alarm1_in;
				4'h5: tx_byte = vout_meas[7:0];
				4'h6: tx_byte = vout_meas[15:8];
				4'h7: tx_byte = iout_meas;
				4'h8: tx_byte = temp_meas;
				BLK_PEC_IDX: tx_byte = crc;
				default: tx_byte = IDLE_BYTE;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			p1_q      <= 5'h00;
			p2_q      <= 5'h00;
			p3_q      <= 5'h00;
			pf_q      <= 5'h00;
			inframe_q <= 1'b0;
			cmdv_q    <= 1'b0;
			cmd_q     <= 8'h00;
			nb_q      <= 3'd0;
			b0_q      <= 8'h00;
			b1_q      <= 8'h00;
			rdph_q    <= 1'b0;
			idx_q     <= 4'h0;
			on_q      <= 1'b1;
			eff_q     <= 1'b1;
			rsc_q     <= 1'b0;
			sw_q      <= 1'b0;
			sp_q      <= VOUT_RST_CODE;
			ov_q      <= OVLIM_DEF;
			vt_q      <= VOUT_DEF;
			pec_q     <= 1'b0;
			bad_q     <= 1'b0;
			isof_q    <= 1'b0;
			isok_q    <= 1'b0;
			rok_q     <= 1'b0;
			rng_q     <= 1'b0;
		end else begin
			p1_q      <= {margin_sel, remote_en_n, addr_sel};
			p2_q      <= p1_q;
			p3_q      <= p2_q;
			pf_q      <= pf_d;
			inframe_q <= inframe_d;
			cmdv_q    <= cmdv_d;
			cmd_q     <= cmd_d;
			nb_q      <= nb_d;
			b0_q      <= b0_d;
			b1_q      <= b1_d;
			rdph_q    <= rdph_d;
			idx_q     <= idx_d;
			on_q      <= on_d;
			eff_q     <= eff_d;
			rsc_q     <= rsc_d;
			sw_q      <= sw_d;
			sp_q      <= sp_d;
			ov_q      <= ov_d;
			vt_q      <= vt_d;
			pec_q     <= pec_d;
			bad_q     <= bad_d;
			isof_q    <= isof_d;
			isok_q    <= isok_d;
			rok_q     <= rok_d;
			rng_q     <= rng_d;
		end
	end

	assign out_enable    = eff_q;
	assign vout_target   = vt_q;
	assign ov_trip_level = ov_q;
	assign restart_clear = rsc_q;
	assign alert_n       = ~bad_q;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	a_op_on: assert property (wr_ok && cmd_q == OPERATION_CMD && b0_q == OP_ON_BYTE
		|=> on_q ##1 (out_enable == !$past(remote_lvl))) else $error("operation on not taken");
	a_op_off: assert property (wr_ok && cmd_q == OPERATION_CMD && b0_q == OP_OFF_BYTE
		|=> !on_q ##1 !out_enable) else $error("operation off not taken");
	a_reset_on: assert property ($fell(rst) |-> on_q)
		else $error("output not on after reset");
	a_clear_flags: assert property (wr_ok && cmd_q == CLEAR_FAULTS_CMD
		|=> !pec_q && !bad_q) else $error("clear command left flags set");
	a_pec_drop: assert property (pec_bad |=> pec_q && $stable(on_q) && $stable(ov_q))
		else $error("bad checksum not flagged or command executed");
	a_bad_alert: assert property (ev.rx && !cmdv_q && !known_cmd(ev.data)
		|=> ##1 !alert_n && st2.bad_cmd) else $error("unsupported code not flagged");
	a_range_hold: assert property (rng_q && !(wr_ok && (cmd_q == OPERATION_CMD ||
		cmd_q == VOUT_SET_CMD)) |=> rng_q) else $error("range flag dropped early");
	a_setpoint_lock: assert property (sw_q |=> sw_q && vout_target == $past(sp_q) &&
		sp_q >= VOUT_MIN_CODE && sp_q <= VOUT_MAX_CODE) else $error("bus setpoint lost");
	a_restart_flag: assert property (restart |=> restart_clear && rok_q ##1 !restart_clear)
		else $error("restart not reported");
	a_remote_mirror: assert property ($stable(remote_en_n) [*6] |->
		st2.remote_enable_level_flag == remote_en_n) else $error("remote level not mirrored");
	a_block_count: assert property (ev.addr && ev.rd && cmdv_q && cmd_q == READ_STATUS_CMD
		|=> tx_byte == BLK_COUNT) else $error("block read count wrong");

	c_op_write: cover property (wr_ok && cmd_q == OPERATION_CMD);
	c_checksum_mismatch_flag: cover property (pec_bad);
	c_block_pec: cover property (ev.tx && idx_q == BLK_PEC_IDX);
	c_setpoint: cover property (wr_ok && cmd_q == VOUT_SET_CMD && rng_clr);
endmodule

//--- dv/pmi_host_model.sv
// bus master model: drives the link clock, pulls the data line, keeps a running checksum
`timescale 1ns/1ps
module pmi_host_model
	import pmi_pkg::*;
#(
	parameter int PH = 4
) (
	input  wire logic clk_sys,
	input  wire logic sda,
	output logic      scl,
	output logic      sda_pull
);
	logic [7:0] crc;

	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
		crc = 8'h00;
	end

	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] x;
		x = c ^ d;
		for (int i = 0; i < 8; i++)
			x = x[7] ? ({x[6:0], 1'b0} ^ CRC_POLY) : {x[6:0], 1'b0};
		return x;
	endfunction

	// data only moves a cycle after the clock fall, never with it
	// link period is 2*PH cycles; low runs PH+1 cycles and high PH-1, so slave data settles first
	task automatic bit_io(input logic b, output logic r);
		step(1);
		sda_pull <= ~b;
		step(PH);
		scl <= 1'b1;
		step(PH - 1);
		r = sda;
		scl <= 1'b0;
	endtask

	task automatic tx(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(b[i], r);
		bit_io(1'b1, r);
		ack = ~r;
		crc = crc8(crc, b);
	endtask

	task automatic rx(input logic last, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			b[i] = r;
		end
		bit_io(last, r);
		crc = crc8(crc, b);
	endtask

	// also serves as repeated start, so the checksum runs on
	task automatic start();
		step(1);
		sda_pull <= 1'b0;
		step(PH);
		scl <= 1'b1;
		step(PH);
		sda_pull <= 1'b1;
		step(PH);
		scl <= 1'b0;
	endtask

	task automatic stop();
		step(1);
		sda_pull <= 1'b1;
		step(PH);
		scl <= 1'b1;
		step(PH);
		sda_pull <= 1'b0;
		step(4 * PH);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] cmd, input int n,
		input logic [15:0] d, input logic bad, output logic ok);
		logic k;
		crc = 8'h00;
		start();
		tx(a, k);
		ok = k;
		tx(cmd, k);
		ok &= k;
		for (int i = 0; i < n; i++) begin
			tx(d[8*i +: 8], k);
			ok &= k;
		end
		tx(crc ^ {7'h00, bad}, k);
		ok &= k;
		stop();
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] r [10]);
		logic k;
		crc = 8'h00;
		start();
		tx(a, k);
		tx(READ_STATUS_CMD, k);
		start();
		tx(a | 8'h01, k);
		for (int i = 0; i < 10; i++)
			rx(i == 9, r[i]);
		stop();
	endtask
endmodule

//--- dv/pmi_cmd_interp_bench.sv
// self-checking bench for the command interpreter over its two-wire link
`timescale 1ns/1ps
module pmi_cmd_interp_bench
	import pmi_pkg::*;
;
	localparam logic [2:0] ADDR_STRAP = 3'h5;
	localparam logic [7:0] AW       = {DEV_ADDR_HI, ADDR_STRAP, 1'b0};
	logic [2:0]  addr_pins = ADDR_STRAP;
	localparam int         OFF_HOLD = 40;
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic        remote_en_n = 1'b0;
	logic        margin_sel = 1'b0;
	logic [15:0] margin_code = 16'h5000;
	logic        auto_restart_cfg = 1'b1;
	logic        high_line = 1'b1;
	logic        iso_pass = 1'b0;
	logic        iso_fail = 1'b0;
	logic [7:0]  st1 = 8'h85, al2 = 8'h3c, al1 = 8'ha2, iout = 8'h21, temp = 8'h37;
	logic [15:0] vout_meas = 16'hbe12;
	logic        scl, sda_pull, sda_oe, sda_out, out_enable, restart_clear, alert_n;
	logic [15:0] vout_target, ov_trip_level;
	wire         sda_line = (sda_oe ? sda_out : 1'b1) & ~sda_pull;
	int          n_fail = 0;
	int          samples_checked = 0;
	int          n_restart = 0;

	initial forever #50 clk_sys = ~clk_sys;

	pmi_host_model pmi_host_model_inst (.clk_sys(clk_sys), .sda(sda_line), .scl(scl),
		.sda_pull(sda_pull));

	pmi_cmd_interp pmi_cmd_interp_inst (.clk_sys(clk_sys), .rst(rst), .scl_in(scl),
		.sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .addr_sel(addr_pins),
		.remote_en_n(remote_en_n), .margin_sel(margin_sel), .margin_code(margin_code),
		.auto_restart_cfg(auto_restart_cfg), .high_line(high_line), .iso_pass(iso_pass),
		.iso_fail(iso_fail), .status1_in(st1), .alarm2_in(al2), .alarm1_in(al1),
		.vout_meas(vout_meas), .iout_meas(iout), .temp_meas(temp), .out_enable(out_enable),
		.vout_target(vout_target), .ov_trip_level(ov_trip_level),
		.restart_clear(restart_clear), .alert_n(alert_n));

	always @(posedge clk_sys) begin
		if (restart_clear === 1'b1)
			n_restart <= n_restart + 1;
	end

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	// a refused checksum may legally go unacknowledged, so only good frames check it
	task automatic w(input logic [7:0] cmd, input int n, input logic [15:0] d, input logic bad);
		logic ok;
		pmi_host_model_inst.wr(AW, cmd, n, d, bad, ok);
		if (!bad)
			chk("ack", 16'h0001, 16'(ok));
		pmi_host_model_inst.step(8);
	endtask

	// fl carries the latched flag bits; live bits come from the bench's own inputs
	task automatic rs(input logic [7:0] fl, input logic iso_ok);
		logic [7:0] r [10];
		logic [7:0] e [9];
		pmi_host_model_inst.rd(AW, r);
		e = '{BLK_COUNT, fl | {1'b0, auto_restart_cfg, 1'b0, high_line, 3'b000, remote_en_n},
			{st1[7], iso_ok, st1[5:0]}, al2, al1, vout_meas[7:0], vout_meas[15:8], iout, temp};
		for (int i = 0; i < 9; i++)
			chk("block byte", 16'(e[i]), 16'(r[i]));
		chk("block checksum", 16'h0000, 16'(pmi_host_model_inst.crc));
	endtask

	initial begin
		repeat (100000) @(posedge clk_sys);
		n_fail++;
		tally_and_finish();
	end

	initial begin
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (10) @(posedge clk_sys);
		chk("out_enable", 16'h0001, 16'(out_enable));
		chk("vout_target", VOUT_RST_CODE, vout_target);
		chk("ov_trip_level", OVLIM_RST_CODE, ov_trip_level);
		chk("alert_n", 16'h0001, 16'(alert_n));
		rs(8'h00, 1'b0);
		margin_sel <= 1'b1;
		iso_pass <= 1'b1;
		iso_fail <= 1'b1;
		@(posedge clk_sys);
		iso_pass <= 1'b0;
		iso_fail <= 1'b0;
		pmi_host_model_inst.step(8);
		chk("vout_target", 16'h5000, vout_target);
		chk("out_enable", 16'h0001, 16'(out_enable));
		chk("alert_n", 16'h0001, 16'(alert_n));
		rs(8'h08, 1'b1);
		w(OPERATION_CMD, 1, 16'(OP_OFF_BYTE), 1'b0);
		chk("out_enable", 16'h0000, 16'(out_enable));
		pmi_host_model_inst.step(OFF_HOLD);
		w(OPERATION_CMD, 1, 16'(OP_ON_BYTE), 1'b0);
		chk("out_enable", 16'h0001, 16'(out_enable));
		chk("restart pulses", 16'h0001, 16'(n_restart));
		rs(8'h04, 1'b0);
		w(8'h55, 0, 16'h0000, 1'b0);
		chk("alert_n", 16'h0000, 16'(alert_n));
		w(VOUT_SET_CMD, 2, 16'h4ed4, 1'b1);
		chk("vout_target", 16'h5000, vout_target);
		w(VOUT_SET_CMD, 2, VOUT_MAX_CODE + 16'h0001, 1'b0);
		chk("vout_target", 16'h5000, vout_target);
		rs(8'ha6, 1'b0);
		w(CLEAR_FAULTS_CMD, 0, 16'h0000, 1'b0);
		chk("alert_n", 16'h0001, 16'(alert_n));
		rs(8'h02, 1'b0);
		w(VOUT_SET_CMD, 2, 16'h4ed4, 1'b0);
		margin_code <= 16'h4100;
		pmi_host_model_inst.step(8);
		chk("vout_target", 16'h4ed4, vout_target);
		for (int i = 0; i < 2; i++) begin
			w(VOUT_SET_CMD, 2, i ? VOUT_MIN_CODE : VOUT_MAX_CODE, 1'b0);
			chk("vout_target", i ? VOUT_MIN_CODE : VOUT_MAX_CODE, vout_target);
		end
		w(OVERVOLTAGE_TRIP_CMD, 2, 16'h1234, 1'b0);
		chk("ov_trip_level", 16'h1234, ov_trip_level);
		rs(8'h00, 1'b0);
		w(8'h55, 0, 16'h0000, 1'b0);
		w(CLEAR_FAULTS_CMD, 1, 16'h0000, 1'b0);
		chk("alert_n", 16'h0000, 16'(alert_n));
		w(CLEAR_FAULTS_CMD, 0, 16'h0000, 1'b0);
		chk("alert_n", 16'h0001, 16'(alert_n));
		auto_restart_cfg <= 1'b0;
		high_line <= 1'b0;
		st1 <= 8'h7a;
		al2 <= 8'hc3;
		al1 <= 8'h5d;
		vout_meas <= 16'h34ab;
		iout <= 8'h9e;
		temp <= 8'h4b;
		remote_en_n <= 1'b1;
		pmi_host_model_inst.step(10);
		chk("out_enable", 16'h0000, 16'(out_enable));
		rs(8'h00, 1'b0);
		remote_en_n <= 1'b0;
		pmi_host_model_inst.step(10);
		chk("out_enable", 16'h0001, 16'(out_enable));
		chk("restart pulses", 16'h0002, 16'(n_restart));
		tally_and_finish();
	end
endmodule
